// File: core/boost_and_led_route_control.sv
// boost_and_led_route_control: boost run/soft-start control and colour led routing
// assumes a host on the two-wire serial port; led sources run on clk_sys
//
// Summary of operation
// RULE1 - clearing the boost run bit halts switching until the bit is set again.
// RULE2 - setting the run bit runs the converter in pulse-frequency mode for 10 ms, then fixed-frequency mode.
// RULE3 - the voltage register takes thermometer codes 00 to ff for nine steps and resets to 3f.
// RULE4 - the frequency field decodes 1xx as 2.00 MHz, 01x as 1.67 MHz, 001 as 1.00 MHz; reset 07.
// RULE5 - the two-bit source select routes group a and group b to pattern, blinking or audio sources.
// RULE6 - an output follows pattern or audio only while its direct on/off bit is set.
// RULE7 - a set gating bit hands that output to the external pwm pin, bits 5..0 red a to blue b.
// RULE8 - only group a can take the blinking source, never group b.
// RULE9 - all led outputs are forced off during the 10 ms soft-start interval.
// RULE10 - with its gating bit clear and outside soft start an output follows its group source and its direct bit only.
`timescale 1ns/1ps
module boost_and_led_route_control
  import boost_led_pkg::*;
#(
  parameter int unsigned SOFT_START_CYCLES = boost_led_pkg::SOFT_START_COUNT,
  parameter logic [6:0]  SLAVE_ADDR        = 7'h2a
) (
  input  wire logic                 clk_sys,
  input  wire logic                 rst,
  input  wire logic                 scl_in,
  input  wire logic                 sda_in,
  output logic                      sda_out,
  output logic                      sda_oe,
  input  wire logic                 pwm_pin,
  input  wire logic [2:0]           pattern_a,
  input  wire logic [2:0]           pattern_b,
  input  wire logic [2:0]           audio_a,
  input  wire logic [2:0]           audio_b,
  input  wire logic [2:0]           blink_a,
  output logic [2:0]                led_group_a,
  output logic [2:0]                led_group_b,
  output logic                      boost_switch_en,
  output logic                      boost_pfm,
  output logic [7:0]                boost_vcode,
  output boost_led_pkg::freq_e      boost_freq
);
  import boost_led_pkg::*;

  // ---------------------------------------------------------------
  // serial register port
  // ---------------------------------------------------------------
  logic       wr_en;
  logic [7:0] wr_addr;
  logic [7:0] wr_data;
  logic [7:0] rd_addr;
  logic [7:0] rd_data;
  logic       sda_out_w;
  logic       sda_oe_w;

  serial_reg_port #(
    .SLAVE_ADDR (SLAVE_ADDR)
  ) u_port (
    .clk_sys (clk_sys),
    .rst     (rst),
    .scl_in  (scl_in),
    .sda_in  (sda_in),
    .sda_out (sda_out_w),
    .sda_oe  (sda_oe_w),
    .wr_en   (wr_en),
    .wr_addr (wr_addr),
    .wr_data (wr_data),
    .rd_addr (rd_addr),
    .rd_data (rd_data)
  );
  assign sda_out = sda_out_w;
  assign sda_oe  = sda_oe_w;

  // ---------------------------------------------------------------
  // registers
  // ---------------------------------------------------------------
  logic [7:0] direct_r, direct_nxt;
  logic [7:0] gate_r,   gate_nxt;
  logic [7:0] enab_r,   enab_nxt;
  logic [7:0] vcode_r,  vcode_nxt;
  logic [7:0] fsel_r,   fsel_nxt;
  logic       vcode_ok;

  assign vcode_ok = ((wr_data & (wr_data + 8'h01)) == 8'h00);

  always_comb begin
    direct_nxt = direct_r;
    gate_nxt   = gate_r;
    enab_nxt   = enab_r;
    vcode_nxt  = vcode_r;
    fsel_nxt   = fsel_r;
    if (wr_en) begin
      case (wr_addr)
        OFS_LED_DIRECT_ONOFF:   direct_nxt = wr_data;
        OFS_EXT_PWM_ROUTING:    gate_nxt   = wr_data & {2'b00, MASK_CHANNELS};
        OFS_BLOCK_ENABLES:      enab_nxt   = wr_data;
        OFS_BOOST_VOLTAGE_CODE: vcode_nxt  = vcode_ok ? wr_data : vcode_r; // [RULE3]
        OFS_BOOST_FREQ_SELECT:  fsel_nxt   = wr_data;
        default:                direct_nxt = direct_r;
      endcase
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      direct_r <= RST_LED_DIRECT_ONOFF;
      gate_r   <= RST_EXT_PWM_ROUTING;
      enab_r   <= RST_BLOCK_ENABLES;
      vcode_r  <= RST_BOOST_VOLTAGE_CODE; // [RULE3]
      fsel_r   <= RST_BOOST_FREQ_SELECT;  // [RULE4]
    end else begin
      direct_r <= direct_nxt;
      gate_r   <= gate_nxt;
      enab_r   <= enab_nxt;
      vcode_r  <= vcode_nxt;
      fsel_r   <= fsel_nxt;
    end
  end

  always_comb begin
    case (rd_addr)
      OFS_LED_DIRECT_ONOFF:   rd_data = direct_r;
      OFS_EXT_PWM_ROUTING:    rd_data = gate_r;
      OFS_BLOCK_ENABLES:      rd_data = enab_r;
      OFS_BOOST_VOLTAGE_CODE: rd_data = vcode_r;
      OFS_BOOST_FREQ_SELECT:  rd_data = fsel_r;
      default:                rd_data = 8'h00;
    endcase
  end

  // ---------------------------------------------------------------
  // boost sequencer
  // ---------------------------------------------------------------
  boost_state_e boost_r, boost_nxt;
  logic [31:0]  soft_cnt_r, soft_cnt_nxt;
  logic         run_req;
  logic         sw_en_nxt;
  logic         pfm_nxt;
  freq_e        freq_dec;

  assign run_req   = enab_r[BIT_STANDBY_N] & enab_r[BIT_BOOST_RUN];
  assign sw_en_nxt = (boost_nxt != BOOST_OFF);  // [RULE1]
  assign pfm_nxt   = (boost_nxt == BOOST_SOFT); // [RULE2]

  always_comb begin
    boost_nxt    = boost_r;
    soft_cnt_nxt = soft_cnt_r;
    case (boost_r)
      BOOST_OFF: begin
        if (run_req) begin
          boost_nxt    = BOOST_SOFT; // [RULE2]
          soft_cnt_nxt = 32'h0;
        end
      end
      BOOST_SOFT: begin
        if (!run_req) begin
          boost_nxt = BOOST_OFF; // [RULE1]
        end else if (soft_cnt_r == SOFT_START_CYCLES - 1) begin
          boost_nxt = BOOST_RUN; // [RULE2]
        end else begin
          soft_cnt_nxt = soft_cnt_r + 32'h1;
        end
      end
      BOOST_RUN: begin
        if (!run_req) begin
          boost_nxt = BOOST_OFF; // [RULE1]
        end
      end
      default: boost_nxt = BOOST_OFF;
    endcase
  end

  always_comb begin
    if (fsel_r[BIT_FREQ_HI]) begin
      freq_dec = FREQ_2M00; // [RULE4]
    end else if (fsel_r[BIT_FREQ_HI-1]) begin
      freq_dec = FREQ_1M67;
    end else begin
      freq_dec = FREQ_1M00;
    end
  end

  // ---------------------------------------------------------------
  // led routing
  // ---------------------------------------------------------------
  logic [1:0] pwm_sync_r;
  logic [5:0] led_nxt;
  logic [5:0] led_r;
  logic [2:0] src_a;
  logic [2:0] src_b;
  logic [1:0] sel;
  logic [5:0] src_ab;

  assign sel    = enab_r[BIT_SEL_HI:BIT_SEL_LO];
  assign src_ab = {src_a, src_b};

  always_comb begin
    case (sel) // [RULE5] [RULE8]
      SEL_PAT_PAT:     begin src_a = pattern_a; src_b = pattern_b; end
      SEL_BLINK_PAT:   begin src_a = blink_a;   src_b = pattern_b; end
      SEL_PAT_AUDIO:   begin src_a = pattern_a; src_b = audio_b;   end
      SEL_AUDIO_AUDIO: begin src_a = audio_a;   src_b = audio_b;   end
      default:         begin src_a = pattern_a; src_b = pattern_b; end
    endcase
  end

  always_comb begin
    for (int i = 0; i < 6; i++) begin
      if (boost_nxt == BOOST_SOFT) begin
        led_nxt[i] = 1'b0; // [RULE9]
      end else if (gate_r[i]) begin
        led_nxt[i] = pwm_sync_r[1]; // [RULE7]
      end else begin
        led_nxt[i] = direct_r[i] & src_ab[i]; // [RULE6] [RULE10]
      end
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      boost_r     <= BOOST_OFF;
      soft_cnt_r  <= 32'h0;
      pwm_sync_r  <= 2'h0;
      led_r       <= 6'h00;
      boost_freq  <= FREQ_2M00;
      boost_switch_en <= 1'b0;
      boost_pfm   <= 1'b0;
    end else begin
      boost_r     <= boost_nxt;
      soft_cnt_r  <= soft_cnt_nxt;
      pwm_sync_r  <= {pwm_sync_r[0], pwm_pin};
      led_r       <= led_nxt;
      boost_freq  <= freq_dec;
      boost_switch_en <= sw_en_nxt;
      boost_pfm   <= pfm_nxt;
    end
  end

  assign led_group_a     = led_r[5:3];
  assign led_group_b     = led_r[2:0];
  assign boost_vcode     = vcode_r;

  // ---------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------
  sequence s_run_set;
    $rose(run_req) && boost_r == BOOST_OFF;
  endsequence
  sequence s_soft_then_run;
    boost_pfm [*8] ##0 boost_switch_en;
  endsequence

  chk_halt_on_clear: assert property (@(posedge clk_sys) disable iff (rst) // [RULE1]
    $fell(run_req) |=> !boost_switch_en until_with run_req)
    else $error("boost kept switching after run bit cleared");
  chk_soft_start_pfm: assert property (@(posedge clk_sys) disable iff (rst) // [RULE2]
    s_run_set |=> s_soft_then_run)
    else $error("soft start did not begin in pfm");
  chk_pwm_after_soft: assert property (@(posedge clk_sys) disable iff (rst) // [RULE2]
    boost_r == BOOST_SOFT && run_req && soft_cnt_r == SOFT_START_CYCLES - 1 |=> boost_r == BOOST_RUN && !boost_pfm)
    else $error("no switch to fixed frequency after soft start");
  chk_vcode_thermo: assert property (@(posedge clk_sys) disable iff (rst) // [RULE3]
    (vcode_r & (vcode_r + 8'h01)) == 8'h00)
    else $error("voltage code not a thermometer code");
  chk_freq_decode: assert property (@(posedge clk_sys) disable iff (rst) // [RULE4]
    $past(fsel_r[2]) |-> boost_freq == FREQ_2M00)
    else $error("frequency decode wrong");
  chk_group_b_noblink: assert property (@(posedge clk_sys) disable iff (rst) // [RULE8]
    sel == SEL_BLINK_PAT && gate_r[2:0] == 3'h0 && boost_nxt != BOOST_SOFT
      |=> led_group_b == $past(direct_r[2:0] & pattern_b))
    else $error("group b routed to blinking");
  chk_direct_needed: assert property (@(posedge clk_sys) disable iff (rst) // [RULE6]
    !direct_r[5] && !gate_r[5] |=> !led_group_a[2])
    else $error("led lit without its direct bit");
  chk_leds_off_soft: assert property (@(posedge clk_sys) disable iff (rst) // [RULE9]
    boost_pfm |-> led_r == 6'h00)
    else $error("led on during soft start");
  chk_pwm_gating: assert property (@(posedge clk_sys) disable iff (rst) // [RULE7]
    gate_r[0] && boost_nxt != BOOST_SOFT |=> led_group_b[0] == $past(pwm_sync_r[1]))
    else $error("gated output not following pwm pin");

endmodule

// File: core/boost_led_pkg.sv
// boost_led_pkg: register map, field positions, reset values, timing constants
// assumes one system clock of 250 MHz shared by all design files
package boost_led_pkg;

  // ---------------------------------------------------------------
  // register offsets
  // ---------------------------------------------------------------
  localparam logic [7:0] OFS_LED_DIRECT_ONOFF   = 8'h00;
  localparam logic [7:0] OFS_EXT_PWM_ROUTING    = 8'h07;
  localparam logic [7:0] OFS_BLOCK_ENABLES      = 8'h08;
  localparam logic [7:0] OFS_BOOST_VOLTAGE_CODE = 8'h0d;
  localparam logic [7:0] OFS_BOOST_FREQ_SELECT  = 8'h0e;

  // ---------------------------------------------------------------
  // reset values
  // ---------------------------------------------------------------
  localparam logic [7:0] RST_LED_DIRECT_ONOFF   = 8'h00;
  localparam logic [7:0] RST_EXT_PWM_ROUTING    = 8'h00;
  localparam logic [7:0] RST_BLOCK_ENABLES      = 8'h00;
  localparam logic [7:0] RST_BOOST_VOLTAGE_CODE = 8'h3f;
  localparam logic [7:0] RST_BOOST_FREQ_SELECT  = 8'h07;

  // ---------------------------------------------------------------
  // field positions
  // ---------------------------------------------------------------
  localparam int unsigned BIT_STANDBY_N  = 6;
  localparam int unsigned BIT_BOOST_RUN  = 5;
  localparam int unsigned BIT_SEL_HI     = 1;
  localparam int unsigned BIT_SEL_LO     = 0;
  localparam int unsigned BIT_FREQ_HI    = 2;
  localparam int unsigned BIT_FREQ_LO    = 0;
  localparam int unsigned BIT_CHAN_HI    = 5;
  localparam logic [5:0]  MASK_CHANNELS  = 6'h3f;

  // ---------------------------------------------------------------
  // source select and frequency codes
  // ---------------------------------------------------------------
  localparam logic [1:0] SEL_PAT_PAT     = 2'h0;
  localparam logic [1:0] SEL_BLINK_PAT   = 2'h1;
  localparam logic [1:0] SEL_PAT_AUDIO   = 2'h2;
  localparam logic [1:0] SEL_AUDIO_AUDIO = 2'h3;

  typedef enum logic [1:0] {
    FREQ_1M00 = 2'b00,
    FREQ_1M67 = 2'b01,
    FREQ_2M00 = 2'b10
  } freq_e;

  typedef enum logic [1:0] {
    BOOST_OFF  = 2'b00,
    BOOST_SOFT = 2'b01,
    BOOST_RUN  = 2'b10
  } boost_state_e;

  // ---------------------------------------------------------------
  // timing
  // ---------------------------------------------------------------
  localparam int unsigned CLK_KHZ          = 250000;
  localparam int unsigned SOFT_START_MS    = 10;
  localparam int unsigned SOFT_START_COUNT = SOFT_START_MS * CLK_KHZ;

endpackage

// File: core/serial_reg_port.sv
// serial_reg_port: two-wire serial slave giving register writes and reads
// assumes scl/sda arrive asynchronously; sda is open drain, oe high pulls low
`timescale 1ns/1ps
module serial_reg_port #(
  parameter logic [6:0] SLAVE_ADDR = 7'h2a
) (
  input  wire logic       clk_sys,
  input  wire logic       rst,
  input  wire logic       scl_in,
  input  wire logic       sda_in,
  output logic            sda_out,
  output logic            sda_oe,
  output logic            wr_en,
  output logic [7:0]      wr_addr,
  output logic [7:0]      wr_data,
  output logic [7:0]      rd_addr,
  input  wire logic [7:0] rd_data
);

  typedef enum logic [2:0] {
    SP_IDLE  = 3'b000,
    SP_ADDR  = 3'b001,
    SP_PTR   = 3'b010,
    SP_WDATA = 3'b011,
    SP_RDATA = 3'b100
  } sp_state_e;

  // ---------------------------------------------------------------
  // pin synchronisers and edge detect
  // ---------------------------------------------------------------
  logic [2:0] scl_sync_r;
  logic [2:0] sda_sync_r;
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      scl_sync_r <= 3'h7;
      sda_sync_r <= 3'h7;
    end else begin
      scl_sync_r <= {scl_sync_r[1:0], scl_in};
      sda_sync_r <= {sda_sync_r[1:0], sda_in};
    end
  end

  logic scl_rise;
  logic scl_fall;
  logic cond_start;
  logic cond_stop;
  assign scl_rise   = scl_sync_r[1] & ~scl_sync_r[2];
  assign scl_fall   = ~scl_sync_r[1] & scl_sync_r[2];
  assign cond_start = scl_sync_r[1] & scl_sync_r[2] & sda_sync_r[2] & ~sda_sync_r[1];
  assign cond_stop  = scl_sync_r[1] & scl_sync_r[2] & ~sda_sync_r[2] & sda_sync_r[1];

  // ---------------------------------------------------------------
  // byte engine
  // ---------------------------------------------------------------
  sp_state_e  state_r,  state_nxt;
  logic [3:0] bit_r,    bit_nxt;
  logic [7:0] shift_r,  shift_nxt;
  logic [7:0] ptr_r,    ptr_nxt;
  logic       oe_r,     oe_nxt;
  logic       we_r,     we_nxt;
  logic [7:0] wa_r,     wa_nxt;
  logic [7:0] wd_r,     wd_nxt;

  always_comb begin
    state_nxt = state_r;
    bit_nxt   = bit_r;
    shift_nxt = shift_r;
    ptr_nxt   = ptr_r;
    oe_nxt    = oe_r;
    we_nxt    = 1'b0;
    wa_nxt    = wa_r;
    wd_nxt    = wd_r;
    if (cond_start) begin
      state_nxt = SP_ADDR;
      bit_nxt   = 4'h0;
      oe_nxt    = 1'b0;
    end else if (cond_stop) begin
      state_nxt = SP_IDLE;
      oe_nxt    = 1'b0;
    end else if (state_r != SP_IDLE && scl_rise) begin
      if (bit_r < 4'h8 && state_r != SP_RDATA) begin
        shift_nxt = {shift_r[6:0], sda_sync_r[1]};
      end
      if (state_r == SP_RDATA && bit_r == 4'h8 && sda_sync_r[1]) begin
        state_nxt = SP_IDLE;
      end
      bit_nxt = bit_r + 4'h1;
    end else if (state_r != SP_IDLE && scl_fall) begin
      if (bit_r == 4'h8) begin
        case (state_r)
          SP_ADDR: begin
            if (shift_r[7:1] == SLAVE_ADDR) begin
              oe_nxt    = 1'b1;
              state_nxt = shift_r[0] ? SP_RDATA : SP_PTR;
            end else begin
              state_nxt = SP_IDLE;
            end
          end
          SP_PTR: begin
            ptr_nxt   = shift_r;
            oe_nxt    = 1'b1;
            state_nxt = SP_WDATA;
          end
          SP_WDATA: begin
            we_nxt  = 1'b1;
            wa_nxt  = ptr_r;
            wd_nxt  = shift_r;
            ptr_nxt = ptr_r + 8'h01;
            oe_nxt  = 1'b1;
          end
          default: begin
            oe_nxt = 1'b0;
          end
        endcase
      end else if (bit_r == 4'h9) begin
        bit_nxt = 4'h0;
        if (state_r == SP_RDATA) begin
          oe_nxt    = ~rd_data[7];
          shift_nxt = {rd_data[6:0], 1'b0};
          ptr_nxt   = ptr_r + 8'h01;
        end else begin
          oe_nxt = 1'b0;
        end
      end else if (state_r == SP_RDATA) begin
        oe_nxt    = ~shift_r[7];
        shift_nxt = {shift_r[6:0], 1'b0};
      end
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      state_r <= SP_IDLE;
      bit_r   <= 4'h0;
      shift_r <= 8'h00;
      ptr_r   <= 8'h00;
      oe_r    <= 1'b0;
      we_r    <= 1'b0;
      wa_r    <= 8'h00;
      wd_r    <= 8'h00;
    end else begin
      state_r <= state_nxt;
      bit_r   <= bit_nxt;
      shift_r <= shift_nxt;
      ptr_r   <= ptr_nxt;
      oe_r    <= oe_nxt;
      we_r    <= we_nxt;
      wa_r    <= wa_nxt;
      wd_r    <= wd_nxt;
    end
  end

  assign sda_out = 1'b0;
  assign sda_oe  = oe_r;
  assign wr_en   = we_r;
  assign wr_addr = wa_r;
  assign wr_data = wd_r;
  assign rd_addr = ptr_r;

endmodule

// File: sim/serial_host_model.sv
// serial_host_model: two-wire host that writes and reads device registers
// assumes the bench resolves the open-drain sda line with a pull-up
`timescale 1ns/1ps
module serial_host_model #(
  parameter logic [6:0] ADDR = 7'h2a,
  parameter int         P    = 10
) (
  input  wire logic clk_sys,
  input  wire logic sda_line,
  output logic      scl,
  output logic      sda_low
);
  // ---------------------------------------------------------------
  // bus phases, each held P clocks
  // ---------------------------------------------------------------
  initial begin
    scl     = 1'b1;
    sda_low = 1'b0;
  end

  task automatic hold();
    repeat (P) @(posedge clk_sys);
  endtask

  task automatic start();
    sda_low <= 1'b0;
    hold();
    scl <= 1'b1;
    hold();
    sda_low <= 1'b1;
    hold();
    scl <= 1'b0;
    hold();
  endtask

  task automatic stop();
    sda_low <= 1'b1;
    hold();
    scl <= 1'b1;
    hold();
    sda_low <= 1'b0;
    hold();
  endtask

  // one byte msb first, then the ack slot with sda released
  task automatic xfer(input logic [7:0] tx, output logic [7:0] rx, output logic ack);
    for (int i = 7; i >= 0; i--) begin
      sda_low <= ~tx[i];
      hold();
      scl <= 1'b1;
      hold();
      rx[i] = sda_line;
      scl <= 1'b0;
      hold();
    end
    sda_low <= 1'b0;
    hold();
    scl <= 1'b1;
    hold();
    ack = ~sda_line;
    scl <= 1'b0;
    hold();
  endtask

  // ---------------------------------------------------------------
  // register transactions
  // ---------------------------------------------------------------
  task automatic wr(input logic [7:0] ptr, input logic [7:0] data);
    logic [7:0] rx;
    logic       a;
    start();
    xfer({ADDR, 1'b0}, rx, a);
    xfer(ptr, rx, a);
    xfer(data, rx, a);
    stop();
  endtask

  task automatic rd(input logic [7:0] ptr, output logic [7:0] data);
    logic [7:0] rx;
    logic       a;
    start();
    xfer({ADDR, 1'b0}, rx, a);
    xfer(ptr, rx, a);
    start();
    xfer({ADDR, 1'b1}, rx, a);
    xfer(8'hff, data, a);
    stop();
  endtask
endmodule

// File: sim/test_boost_and_led_route_control.sv
// test_boost_and_led_route_control: routing table, registers, boost soft-start
// assumes serial_host_model as register host and a pull-up on sda
`timescale 1ns/1ps
module test_boost_and_led_route_control;
  import boost_led_pkg::*;
  typedef struct packed {
    logic [1:0] sel;
    logic [7:0] direct;
    logic [7:0] gate;
    logic       pwm;
    logic [2:0] exp_a;
    logic [2:0] exp_b;
  } row_s;
  localparam int SOFT = 200;
  logic       clk_sys = 1'b0;
  logic       rst     = 1'b1;
  logic       pwm_pin = 1'b0;
  logic       scl, sda_low, sda_out, sda_oe, sda_line, boost_switch_en, boost_pfm;
  logic [2:0] led_group_a, led_group_b;
  logic [2:0] pattern_a = 3'h5, pattern_b = 3'h6, audio_a = 3'h3, audio_b = 3'h4, blink_a = 3'h1;
  logic [7:0] boost_vcode, rd_val;
  freq_e      boost_freq;
  int         n_mismatch = 0;
  int         n_checks   = 0;
  row_s       rows [10] = '{
    '{2'h0, 8'h3f, 8'h00, 1'b0, 3'h5, 3'h6}, '{2'h1, 8'h3f, 8'h00, 1'b0, 3'h1, 3'h6},
    '{2'h2, 8'h3f, 8'h00, 1'b0, 3'h5, 3'h4}, '{2'h3, 8'h3f, 8'h00, 1'b0, 3'h3, 3'h4},
    '{2'h3, 8'h28, 8'h00, 1'b1, 3'h1, 3'h0}, '{2'h0, 8'h00, 8'h00, 1'b1, 3'h0, 3'h0},
    '{2'h0, 8'h00, 8'h3f, 1'b1, 3'h7, 3'h7}, '{2'h0, 8'h00, 8'h3f, 1'b0, 3'h0, 3'h0},
    '{2'h0, 8'h3f, 8'h21, 1'b0, 3'h1, 3'h6}, '{2'h0, 8'h3f, 8'h21, 1'b1, 3'h5, 3'h7}};
  logic [7:0] reg_ofs [6] = '{8'h00, 8'h07, 8'h08, 8'h0d, 8'h0e, 8'h05};
  logic [7:0] reg_rst [6] = '{8'h00, 8'h00, 8'h00, 8'h3f, 8'h07, 8'h00};
  logic [7:0] freq_wr [6] = '{8'h01, 8'h04, 8'h03, 8'h06, 8'h02, 8'h00};
  logic [1:0] freq_ex [6] = '{2'b00, 2'b10, 2'b01, 2'b10, 2'b01, 2'b00};

  // ---------------------------------------------------------------
  // clock, wire resolution, instances
  // ---------------------------------------------------------------
  always #2 clk_sys = ~clk_sys;
  assign sda_line = ~(sda_low | (sda_oe & ~sda_out));

  boost_and_led_route_control #(.SOFT_START_CYCLES(SOFT), .SLAVE_ADDR(7'h2a)) u_dut (
    .clk_sys(clk_sys), .rst(rst), .scl_in(scl), .sda_in(sda_line), .sda_out(sda_out),
    .sda_oe(sda_oe), .pwm_pin(pwm_pin), .pattern_a(pattern_a), .pattern_b(pattern_b),
    .audio_a(audio_a), .audio_b(audio_b), .blink_a(blink_a), .led_group_a(led_group_a),
    .led_group_b(led_group_b), .boost_switch_en(boost_switch_en), .boost_pfm(boost_pfm),
    .boost_vcode(boost_vcode), .boost_freq(boost_freq));

  serial_host_model #(.ADDR(7'h2a), .P(10)) u_host (
    .clk_sys(clk_sys), .sda_line(sda_line), .scl(scl), .sda_low(sda_low));

  // ---------------------------------------------------------------
  // compare and closing
  // ---------------------------------------------------------------
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  initial begin
    repeat (90000) @(posedge clk_sys);
    n_mismatch++;
    report_and_stop();
  end

  // ---------------------------------------------------------------
  // tests
  // ---------------------------------------------------------------
  initial begin
    repeat (3) @(posedge clk_sys);
    rst <= 1'b0;
    repeat (5) @(posedge clk_sys);
    chk(boost_vcode, 8'h3f);
    chk({6'h0, boost_freq}, 8'h02);
    chk({6'h0, boost_switch_en, boost_pfm}, 8'h00);
    for (int i = 0; i < 6; i++) begin
      u_host.rd(reg_ofs[i], rd_val);
      chk(rd_val, reg_rst[i]);
    end
    for (int i = 0; i < 10; i++) begin
      pwm_pin <= rows[i].pwm;
      u_host.wr(OFS_LED_DIRECT_ONOFF, rows[i].direct);
      u_host.wr(OFS_EXT_PWM_ROUTING, rows[i].gate);
      u_host.wr(OFS_BLOCK_ENABLES, {6'h0, rows[i].sel});
      repeat (8) @(posedge clk_sys);
      chk({5'h0, led_group_a}, {5'h0, rows[i].exp_a});
      chk({5'h0, led_group_b}, {5'h0, rows[i].exp_b});
    end
    for (int i = 0; i < 9; i++) begin
      u_host.wr(OFS_BOOST_VOLTAGE_CODE, 8'hff >> (8 - i));
      chk(boost_vcode, 8'hff >> (8 - i));
    end
    u_host.wr(OFS_BOOST_VOLTAGE_CODE, 8'h05);
    chk(boost_vcode, 8'hff);
    for (int i = 0; i < 6; i++) begin
      u_host.wr(OFS_BOOST_FREQ_SELECT, freq_wr[i]);
      chk({6'h0, boost_freq}, {6'h0, freq_ex[i]});
    end
    u_host.wr(OFS_EXT_PWM_ROUTING, 8'hff);
    u_host.rd(OFS_EXT_PWM_ROUTING, rd_val);
    chk(rd_val, 8'h3f);
    u_host.wr(OFS_EXT_PWM_ROUTING, 8'h00);
    u_host.wr(OFS_LED_DIRECT_ONOFF, 8'h3f);
    pattern_a <= 3'h2;
    pattern_b <= 3'h1;
    repeat (4) @(posedge clk_sys);
    chk({2'h0, led_group_a, led_group_b}, 8'h11);
    pattern_a <= 3'h5;
    pattern_b <= 3'h6;
    u_host.wr(OFS_BLOCK_ENABLES, 8'h60);
    chk({6'h0, boost_switch_en, boost_pfm}, 8'h03);
    chk({2'h0, led_group_a, led_group_b}, 8'h00);
    repeat (SOFT) @(posedge clk_sys);
    chk({6'h0, boost_switch_en, boost_pfm}, 8'h02);
    chk({2'h0, led_group_a, led_group_b}, 8'h2e);
    u_host.wr(OFS_BLOCK_ENABLES, 8'h40);
    chk({6'h0, boost_switch_en, boost_pfm}, 8'h00);
    repeat (SOFT) @(posedge clk_sys);
    chk({6'h0, boost_switch_en, boost_pfm}, 8'h00);
    u_host.wr(OFS_BLOCK_ENABLES, 8'h61);
    chk({6'h0, boost_switch_en, boost_pfm}, 8'h03);
    chk({2'h0, led_group_a, led_group_b}, 8'h00);
    repeat (SOFT) @(posedge clk_sys);
    chk({2'h0, led_group_a, led_group_b}, 8'h0e);
    rst <= 1'b1;
    repeat (2) @(posedge clk_sys);
    chk(boost_vcode, 8'h3f);
    chk({6'h0, boost_switch_en, boost_pfm}, 8'h00);
    rst <= 1'b0;
    repeat (2) @(posedge clk_sys);
    chk({6'h0, boost_freq}, 8'h02);
    chk({2'h0, led_group_a, led_group_b}, 8'h00);
    report_and_stop();
  end
endmodule
